// file: shared/spc_pkg.sv
// Constants shared by the serial configuration port and its pin synchroniser.
// Assumes a single 250 MHz core clock that samples every serial pin.
//
// Summary of operation
// [RQ1] Writing reset bit starts self-clearing device reset.
// [RQ2] Bit-order control selects low-first or high-first shifting.
// [RQ3] Streaming address steps up or down per control.
// [RQ4] Output control picks four-wire or three-wire port.
// [RQ5] Upper nibble mirrors lower nibble, bit reversed.
// [RQ6] First configuration register resets to all zero.
// [RQ7] Single-instruction control limits transaction to one byte.
package spc_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int             ADDR_W      = 15;       // Register address width.
    localparam int             INSTR_W     = 16;       // Read flag plus address.
    localparam int             BYTE_W      = 8;        // Data byte width.
    localparam int             RW_POS      = 15;       // Read flag position in the instruction.

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [14:0]    OFS_CFG_A   = 15'h0000; // interface_config_a.
    localparam logic [14:0]    OFS_CFG_B   = 15'h0001; // interface_config_b.

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int             POS_RESET   = 0;        // self_clearing_reset_bit.
    localparam int             POS_ORDER   = 1;        // low_bit_first_order.
    localparam int             POS_STEP    = 2;        // address_step_up.
    localparam int             POS_OUTPUT  = 3;        // four_wire_output_on.
    localparam int             POS_SINGLE  = 7;        // one_instruction_only.
    localparam logic [7:0]     RST_CFG_A   = 8'h00;    // interface_config_a after reset.
    localparam logic [7:0]     RST_CFG_B   = 8'h00;    // interface_config_b after reset.

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam logic [3:0]     SOFT_RESET_CYCLES = 4'h8; // Length of the soft reset pulse.
    localparam logic [2:0]     PIN_IDLE    = 3'h2;     // Idle levels of {data, select_n, clock}.

endpackage

// file: shared/spc_link_if.sv
// Carries the settled serial pin events from the synchroniser to the core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface spc_link_if;
    logic sclk_rise;   // One-cycle pulse on a settled clock rising edge.
    logic sclk_fall;   // One-cycle pulse on a settled clock falling edge.
    logic sel;         // High while the host selects the port.
    logic din;         // Settled serial input bit.

    // The synchroniser drives the events.
    modport sync_mp (output sclk_rise, output sclk_fall, output sel, output din);
    // The core only listens.
    modport core_mp (input sclk_rise, input sclk_fall, input sel, input din);
endinterface

// file: src/spc_sync.sv
// Three-stage synchroniser and edge finder for the serial pins.
// Assumes the pins are asynchronous to clk and far slower than it.
`timescale 1ns/1ps
module spc_sync
    import spc_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Raw pins: bit 0 clock, bit 1 select_n, bit 2 data.
    input  wire logic [2:0] pins,
    // Settled events toward the core.
    spc_link_if.sync_mp lnk
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] s1;    // First stage, read only by the second.
        logic [2:0] s2;    // Second stage.
        logic [2:0] s3;    // Third stage.
        logic [2:0] stab;  // Level accepted once stages two and three agree.
        logic       rise;  // Clock rising edge pulse.
        logic       fall;  // Clock falling edge pulse.
    } spc_sync_s;

    spc_sync_s q;
    spc_sync_s d;
    logic [2:0] agree;     // Stages two and three match.

    // Next state: a level change counts only when stages two and three agree,
    // which filters a single-cycle glitch caught by the second stage.
    always_comb begin
        d       = q;
        agree   = q.s2 ~^ q.s3;
        d.s1    = pins;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.stab  = (agree & q.s2) | (~agree & q.stab);
        d.rise  = d.stab[0] & ~q.stab[0];
        d.fall  = ~d.stab[0] & q.stab[0];
    end

    // Registers, frozen while the enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, stab: PIN_IDLE, rise: 1'b0, fall: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign lnk.sclk_rise = q.rise;
    assign lnk.sclk_fall = q.fall;
    assign lnk.sel       = ~q.stab[1];
    assign lnk.din       = q.stab[2];

    // A clock edge can never be both rising and falling.
    chk_edge_exclusive: assert property (@(posedge clk) disable iff (!rst_n) !(q.rise && q.fall))
        else $error("sync: rise and fall together");

endmodule

// file: src/spc_serial_cfg.sv
// Serial control port slave holding the two interface configuration registers.
// Assumes a host drives clock idle low, samples on rising and shifts on falling edges.
`timescale 1ns/1ps
module spc_serial_cfg
    import spc_pkg::*;
#(
    parameter logic [3:0] SOFT_RESET_LEN = SOFT_RESET_CYCLES  // Soft reset pulse length in cycles.
)
(
    // Clock, reset and enable.
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Serial pins from the host.
    input  wire logic sclk,
    input  wire logic csb_n,
    input  wire logic sdio_i,
    output wire logic sdio_o,
    output wire logic sdio_oe,
    output wire logic sdo_o,
    output wire logic sdo_oe,
    // Settings toward the rest of the device.
    output wire logic soft_reset,
    output wire logic low_bit_first_order,
    output wire logic address_step_up,
    output wire logic four_wire_output_on,
    output wire logic one_instruction_only
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The reset assertion below unrolls the pulse, so it stays short.
    if (SOFT_RESET_LEN < 4'h1 || SOFT_RESET_LEN > 4'h8) begin : g_bad_len
        $error("SOFT_RESET_LEN must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    spc_link_if lnk ();

    spc_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pins  ({sdio_i, csb_n, sclk}),
        .lnk   (lnk.sync_mp)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} spc_state_e;

    typedef struct packed {
        spc_state_e   state;    // Transaction phase.
        logic [3:0]   bit_cnt;  // Bits taken in the current field.
        logic [15:0]  sh;       // Input shift register.
        logic         rw;       // High for a read transaction.
        logic [14:0]  addr;     // Current register address.
        logic [7:0]   tx;       // Read byte still to be shifted out.
        logic         out;      // Bit on the output line.
        logic [3:1]   cfg_a;    // Writable bits 3..1 of interface_config_a.
        logic         single;   // one_instruction_only.
        logic [3:0]   rst_cnt;  // Soft reset cycles left.
    } spc_core_s;

    spc_core_s  q;
    spc_core_s  d;
    logic       lsb;            // Current bit order.
    logic       rst_on;         // Soft reset in progress.
    logic [3:0] low_nib;        // Lower nibble of interface_config_a.
    logic [7:0] reg_a;          // Read value of interface_config_a.
    logic [15:0] sh_n;          // Shift register with the new bit.
    logic [7:0] rx_byte;        // Byte just completed.
    logic [14:0] nxt_addr;      // Next streaming address.

    assign lsb     = q.cfg_a[POS_ORDER];
    assign rst_on  = q.rst_cnt != 4'h0;
    // The reset bit reads one exactly while the reset runs, so it clears itself.
    assign low_nib = {q.cfg_a, rst_on};
    // [RQ5] Mirror nibble
    assign reg_a   = {low_nib[0], low_nib[1], low_nib[2], low_nib[3], low_nib};

    // Read value of any address; unmapped addresses read zero.
    function automatic logic [7:0] read_byte(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_CFG_A) begin
            v = reg_a;
        end else if (a == OFS_CFG_B) begin
            v[POS_SINGLE] = q.single;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // One process walks the frame: instruction, then data bytes until
    // the host deselects or a single-instruction transfer ends.
    always_comb begin
        d         = q;
        // [RQ2] Shift order
        sh_n      = lsb ? {lnk.din, q.sh[15:1]} : {q.sh[14:0], lnk.din};
        rx_byte   = lsb ? sh_n[15:8] : sh_n[7:0];
        // [RQ3] Address direction
        nxt_addr  = q.cfg_a[POS_STEP] ? q.addr + 15'h0001 : q.addr - 15'h0001;
        if (rst_on) begin
            // [RQ1] Soft reset run
            // [RQ6] Reset defaults
            d.rst_cnt = q.rst_cnt - 4'h1;
            d.state   = ST_IDLE;
            d.cfg_a   = RST_CFG_A[3:1];
            d.single  = RST_CFG_B[POS_SINGLE];
            d.out     = 1'b0;
        end else if (!lnk.sel) begin
            // Deselect ends any transaction at once.
            d.state = ST_IDLE;
        end else begin
            unique case (q.state)
                ST_IDLE: begin
                    d.state   = ST_INSTR;
                    d.bit_cnt = 4'h0;
                    d.out     = 1'b0;
                end
                ST_INSTR: begin
                    if (lnk.sclk_rise) begin
                        d.sh      = sh_n;
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'hF) begin
                            // Instruction complete: latch it and fetch the first byte.
                            d.rw      = sh_n[RW_POS];
                            d.addr    = sh_n[14:0];
                            d.tx      = read_byte(sh_n[14:0]);
                            d.bit_cnt = 4'h0;
                            d.state   = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (lnk.sclk_fall && q.rw) begin
                        // [RQ2] Output order
                        d.out = lsb ? q.tx[0] : q.tx[7];
                        d.tx  = lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0};
                    end
                    if (lnk.sclk_rise) begin
                        d.sh      = sh_n;
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'h7) begin
                            d.bit_cnt = 4'h0;
                            if (!q.rw && q.addr == OFS_CFG_A) begin
                                // Upper nibble is read-only and ignored.
                                d.cfg_a = rx_byte[3:1];
                                if (rx_byte[POS_RESET]) begin
                                    // [RQ1] Reset start
                                    d.rst_cnt = SOFT_RESET_LEN;
                                end
                            end else if (!q.rw && q.addr == OFS_CFG_B) begin
                                d.single = rx_byte[POS_SINGLE];
                            end
                            if (q.single) begin
                                // [RQ7] Single transfer stop
                                d.state = ST_DONE;
                            end else begin
                                // [RQ3] Streaming step
                                d.addr = nxt_addr;
                                d.tx   = read_byte(nxt_addr);
                            end
                        end
                    end
                end
                ST_DONE: begin
                    // Further bits are ignored until deselect.
                    d.state = ST_DONE;
                end
            endcase
        end
    end

    // Registers, frozen while the enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{state: ST_IDLE, bit_cnt: 4'h0, sh: 16'h0000, rw: 1'b0, addr: 15'h0000,
                   tx: 8'h00, out: 1'b0, cfg_a: RST_CFG_A[3:1], single: RST_CFG_B[POS_SINGLE],
                   rst_cnt: 4'h0};
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // [RQ4] Wire mode
    // Three-wire turns the shared data pin around; four-wire uses its own line.
    assign sdio_oe              = lnk.sel && q.state == ST_DATA && q.rw && !q.cfg_a[POS_OUTPUT];
    assign sdo_oe               = lnk.sel && q.state == ST_DATA && q.rw && q.cfg_a[POS_OUTPUT];
    assign sdio_o               = q.out;
    assign sdo_o                = q.out;
    assign soft_reset           = rst_on;
    assign low_bit_first_order  = q.cfg_a[POS_ORDER];
    assign address_step_up      = q.cfg_a[POS_STEP];
    assign four_wire_output_on  = q.cfg_a[POS_OUTPUT];
    assign one_instruction_only = q.single;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence seq_reset_hold;
        soft_reset [*8] ##1 !soft_reset;
    endsequence

    sequence seq_data_byte_end;
        q.state == ST_DATA && lnk.sclk_rise && q.bit_cnt == 4'h7 && lnk.sel && !rst_on;
    endsequence

    chk_reset_self_clear: assert property ( // [RQ1]
        @(posedge clk) disable iff (!rst_n || !ce || SOFT_RESET_LEN != 4'h8)
        $rose(soft_reset) |-> seq_reset_hold)
        else $error("soft reset did not clear after its pulse");

    chk_out_bit_order: assert property ( // [RQ2]
        @(posedge clk) disable iff (!rst_n || !ce)
        (q.state == ST_DATA && q.rw && lnk.sclk_fall && lnk.sel && !rst_on)
        |=> sdio_o == (low_bit_first_order ? $past(q.tx[0]) : $past(q.tx[7])))
        else $error("read bit left in wrong order");

    chk_addr_step_dir: assert property ( // [RQ3]
        @(posedge clk) disable iff (!rst_n || !ce)
        (seq_data_byte_end and (!q.single && q.rw))
        |=> q.addr == (address_step_up ? $past(q.addr) + 15'h0001 : $past(q.addr) - 15'h0001))
        else $error("streaming address stepped wrong way");

    chk_wire_mode_pins: assert property ( // [RQ4]
        @(posedge clk) disable iff (!rst_n)
        !(sdio_oe && sdo_oe) && (sdo_oe -> four_wire_output_on) && (sdio_oe -> !four_wire_output_on))
        else $error("output driven on wrong line for wire mode");

    chk_mirror_nibble: assert property ( // [RQ5]
        @(posedge clk) disable iff (!rst_n)
        reg_a[7] == soft_reset && reg_a[6] == low_bit_first_order
        && reg_a[5] == address_step_up && reg_a[4] == four_wire_output_on)
        else $error("upper nibble does not mirror lower");

    chk_reset_zero_cfg: assert property ( // [RQ6]
        @(posedge clk) disable iff (!rst_n || !ce)
        $fell(soft_reset) |-> reg_a == 8'h00 && !one_instruction_only)
        else $error("configuration not zero after soft reset");

    chk_single_stop: assert property ( // [RQ7]
        @(posedge clk) disable iff (!rst_n || !ce)
        // A soft reset started by this very byte may abort the stop state.
        (seq_data_byte_end and q.single) |=> q.state == ST_DONE ##1 (q.state == ST_DONE || !lnk.sel || rst_on))
        else $error("single instruction did not end transfer");

endmodule

// file: verification/spc_host_model.sv
// Behavioural host that drives the serial control port as a mode 0 master.
// Assumes the bench resolves the shared data wire and calls xfer one frame at a time.
`timescale 1ns/1ps
module spc_host_model (
    // Pins driven by the host.
    output logic      sclk,
    output logic      csb_n,
    output logic      sdio_h,
    // Lines sampled from the device.
    input  wire logic sdio_w,
    input  wire logic sdo_o
);
    // --------------------------------------------------------------
    // Idle pins
    // --------------------------------------------------------------
    // The link clock stands low between frames and select stays high.
    initial begin
        sclk   = 1'b0;
        csb_n  = 1'b1;
        sdio_h = 1'b0;
    end

    // --------------------------------------------------------------
    // One frame: instruction word, then nb data bytes
    // --------------------------------------------------------------
    // Bits change on the falling link edge and are taken on the rising one.
    task automatic xfer(input logic rd, input logic [14:0] adr, input int nb, input logic [15:0] wd,
                        input logic lsb, input logic four, output logic [15:0] rdv);
        logic [15:0] ins;
        int          pos;
        ins = {rd, adr};
        rdv = 16'h0000;
        csb_n <= 1'b0;
        #100;
        for (int i = 0; i < 16 + 8 * nb; i++) begin
            pos = (i < 16) ? (lsb ? i : 15 - i) : (8 * ((i - 16) / 8) + (lsb ? (i % 8) : 7 - (i % 8)));
            // A reading host keeps driving a toggling value nobody may trust; the device wins the wire while it drives.
            sdio_h <= (i < 16) ? ins[pos] : (rd ? ~sdio_h : wd[pos]);
            #80;
            if (i >= 16) begin
                rdv[pos] = four ? sdo_o : sdio_w;
            end
            sclk <= 1'b1;
            #80;
            sclk <= 1'b0;
        end
        #80;
        csb_n  <= 1'b1;
        sdio_h <= ~sdio_h;
        #80;
    endtask
endmodule

// file: verification/tb_spc_serial_cfg.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model frames every transfer and the core clock runs at 250 MHz.
`timescale 1ns/1ps
module tb_spc_serial_cfg;
    import spc_pkg::*;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic        clk, rst_n, ce;                        // Core clock, reset, enable.
    wire logic   sclk, csb_n, sdio_h, sdio_o, sdio_oe;  // Serial pins.
    wire logic   sdo_o, sdo_oe, soft_reset;             // Output line and soft reset.
    wire logic   lbf, step, four, single;               // Settings from the port.
    wire logic   sdio_w = sdio_oe ? sdio_o : sdio_h;    // Shared wire, device wins when it drives.
    wire logic [4:0] outs = {soft_reset, lbf, step, four, single};
    int          bad_count, num_checks, rst_cycles;     // Tallies.
    logic        seen_io, seen_so;                      // Output enables seen in a frame.
    logic [15:0] rv;                                    // Last read data.

    spc_serial_cfg i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .csb_n(csb_n),
        .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .soft_reset(soft_reset), .low_bit_first_order(lbf), .address_step_up(step),
        .four_wire_output_on(four), .one_instruction_only(single));
    spc_host_model i_host (.sclk(sclk), .csb_n(csb_n), .sdio_h(sdio_h), .sdio_w(sdio_w), .sdo_o(sdo_o));

    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Count soft reset cycles and note which line the device drove.
    always @(posedge clk) begin
        if (soft_reset) rst_cycles <= rst_cycles + 1;
        if (sdio_oe) seen_io <= 1'b1;
        if (sdo_oe) seen_so <= 1'b1;
    end

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One frame, then a settle gap so settings reach the outputs.
    task automatic acc(input logic rd, input logic [14:0] adr, input int nb, input logic [15:0] wd,
                       input logic lsb, input logic fw);
        seen_io = 1'b0;
        seen_so = 1'b0;
        i_host.xfer(rd, adr, nb, wd, lsb, fw, rv);
        repeat (8) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("Checks made: %0d, mismatches: %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_after_reset();
        check({11'h000, outs}, 16'h0000);
        acc(1'b1, OFS_CFG_A, 1, 16'h0000, 1'b0, 1'b0);
        check(rv, 16'h0000);
        check({14'h0000, seen_io, seen_so}, 16'h0002);
        acc(1'b1, OFS_CFG_B, 1, 16'h0000, 1'b0, 1'b0);
        check(rv, 16'h0000);
    endtask
    // Mirror bits are read-only; bit 7 repeats bit 0 down to bit 4 repeating bit 3.
    // The read comes back low bit first on the separate line.
    task automatic t_mirror();
        acc(1'b0, OFS_CFG_A, 1, 16'h00FE, 1'b0, 1'b0);
        check({11'h000, outs}, 16'h000E);
        check({14'h0000, seen_io, seen_so}, 16'h0000);
        acc(1'b1, OFS_CFG_A, 1, 16'h0000, 1'b1, 1'b1);
        check(rv, 16'h007E);
        check({14'h0000, seen_io, seen_so}, 16'h0001);
    endtask
    // Streams reads in both directions and writes downward only.
    task automatic t_stream();
        acc(1'b1, OFS_CFG_A, 2, 16'h0000, 1'b1, 1'b1);
        check(rv, 16'h007E);
        acc(1'b0, OFS_CFG_A, 1, 16'h000A, 1'b1, 1'b1);
        check({11'h000, outs}, 16'h000A);
        acc(1'b1, OFS_CFG_B, 2, 16'h0000, 1'b1, 1'b1);
        check(rv, 16'h5A00);
        acc(1'b0, OFS_CFG_B, 2, 16'h0800, 1'b1, 1'b1);
        check({11'h000, outs}, 16'h0002);
        acc(1'b1, OFS_CFG_A, 1, 16'h0000, 1'b0, 1'b1);
        check(rv, 16'h0018);
    endtask
    // With one instruction only, a second byte must not reach the next register.
    task automatic t_single();
        acc(1'b0, OFS_CFG_B, 1, 16'h0080, 1'b0, 1'b1);
        check({11'h000, outs}, 16'h0003);
        acc(1'b0, OFS_CFG_B, 2, 16'h0C80, 1'b0, 1'b1);
        check({11'h000, outs}, 16'h0003);
        acc(1'b1, OFS_CFG_B, 1, 16'h0000, 1'b0, 1'b1);
        check(rv, 16'h0080);
        acc(1'b0, OFS_CFG_B, 1, 16'h0000, 1'b0, 1'b1);
        check({11'h000, outs}, 16'h0002);
    endtask
    // Soft reset pulses for its set length and leaves every setting cleared.
    task automatic t_soft();
        acc(1'b0, OFS_CFG_B, 1, 16'h0080, 1'b0, 1'b1);
        rst_cycles = 0;
        acc(1'b0, OFS_CFG_A, 1, 16'h000D, 1'b0, 1'b1);
        check(16'(rst_cycles), {12'h000, SOFT_RESET_CYCLES});
        check({11'h000, outs}, 16'h0000);
        acc(1'b1, OFS_CFG_A, 1, 16'h0000, 1'b0, 1'b0);
        check(rv, 16'h0000);
        acc(1'b1, OFS_CFG_B, 1, 16'h0000, 1'b0, 1'b0);
        check(rv, 16'h0000);
    endtask

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        bad_count = 0;
        num_checks = 0;
        rst_cycles = 0;
        seen_io = 1'b0;
        seen_so = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_after_reset();
        t_mirror();
        t_stream();
        t_single();
        t_soft();
        wrap_up();
    end
    // About twenty frames of four to five and a half microseconds each fit well inside this span.
    initial begin
        #300000;
        bad_count++;
        wrap_up();
    end
endmodule
